// >>> include/flash_erase_pkg.sv
// package: constants and types for the program flash row erase sequencer
package flash_erase_pkg;
   // wishbone register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] UNLOCK_OFFSET = 8'h04;
   localparam logic [7:0] TPTR_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   localparam logic [7:0] MASK_OFFSET = 8'h10;
   localparam logic [7:0] PROT_OFFSET = 8'h14;
   // memory_control_one field positions
   localparam int CTRL_GO_BIT = 1;
   localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
   localparam int CTRL_FREE_BIT = 4;
   localparam int CTRL_TARGET_LO = 6;
   localparam int CTRL_ERR_BIT = 3;
   localparam logic [1:0] TARGET_PROGRAM_STORE = 2'h2;
   // unlock key pair
   localparam logic [7:0] UNLOCK_KEY_A = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_B = 8'hAA;
   // table pointer geometry
   localparam int TPTR_WIDTH = 22;
   localparam int ROW_LSB = 6;
   localparam int ROW_WORDS = 64;
   localparam int ROW_BYTES = 128;
   // status and mask bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;
   // erase time
   localparam int ERASE_TIME_US = 10;
   localparam int CLK_MHZ = 200;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_KEYED = 2'b01,
      ST_ERASE = 2'b11
   } seq_state_t;

   typedef struct packed {
      logic [15:0] row;
      logic start;
   } erase_req_t;
endpackage : flash_erase_pkg

// >>> hw/program_flash_row_erase.sv
// design: program flash row erase sequencer with wishbone register access
// How it works
// - erase request clears a whole row of 64 words, 128 bytes
// - row index is table pointer bits 21:6; bits 5:0 are ignored
// - no single word erase and no bulk erase from this path
// - cpu is held stalled while the erase runs
// - internal timer ends the erase, software does nothing
// - protected row: go cleared, erase skipped, error flag set
// - completion clears go, sets done flag, irq only if enabled
// - erase leaves write latches and write enable unchanged
// - erase cut short by abort sets the error flag
// - go with invalid table pointer sets the error flag
`timescale 1ns/10ps
`default_nettype none
module program_flash_row_erase #(
   parameter int ERASE_COUNT = flash_erase_pkg::ERASE_CYCLES,
   parameter logic [15:0] ROW_LIMIT = 16'h0400
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic abort_pin,
   output logic cpu_stall,
   output logic row_erase_strobe,
   output logic [15:0] row_erase_index,
   output logic irq
);
   localparam int CW = $clog2(ERASE_COUNT + 1);
   // reset values of the control, flag and protect registers, the row index output and the abort synchronizer
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] FLAG_RESET = 2'h0;
   localparam logic [15:0] PROT_RESET = 16'h0000;
   localparam logic [15:0] INDEX_RESET = 16'h0000;
   localparam logic [1:0] SYNC_RESET = 2'h0;

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [flash_erase_pkg::TPTR_WIDTH-1:0] tptr_reg;
   logic [1:0] status_reg;
   logic [1:0] status_next;
   logic [1:0] mask_reg;
   logic [15:0] prot_reg;
   logic [CW-1:0] count_reg;
   flash_erase_pkg::seq_state_t state_reg;
   flash_erase_pkg::seq_state_t state_next;
   logic [1:0] abort_sync_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;

   // bus decode
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
   // writes commit at the edge where the master sees ack, while the request still stands
   wire bus_wr = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
   wire wr_ctrl = bus_wr & (wb_adr_i == flash_erase_pkg::CTRL_OFFSET);
   wire wr_unlock = bus_wr & (wb_adr_i == flash_erase_pkg::UNLOCK_OFFSET);
   wire wr_tptr = bus_wr & (wb_adr_i == flash_erase_pkg::TPTR_OFFSET);
   wire wr_status = bus_wr & (wb_adr_i == flash_erase_pkg::STATUS_OFFSET);
   wire wr_mask = bus_wr & (wb_adr_i == flash_erase_pkg::MASK_OFFSET);
   wire wr_prot = bus_wr & (wb_adr_i == flash_erase_pkg::PROT_OFFSET);
   wire [7:0] wdata = wb_dat_i[7:0];

   // control fields
   wire go_bit = ctrl_reg[flash_erase_pkg::CTRL_GO_BIT];
   wire write_enable_bit = ctrl_reg[flash_erase_pkg::CTRL_WRITE_ENABLE_BIT_BIT];
   wire free = ctrl_reg[flash_erase_pkg::CTRL_FREE_BIT];
   wire [1:0] target = ctrl_reg[flash_erase_pkg::CTRL_TARGET_LO +: 2];
   wire setup_ok = write_enable_bit & free & (target == flash_erase_pkg::TARGET_PROGRAM_STORE);

   // row select ignores low pointer bits
   wire [15:0] row_sel = tptr_reg[flash_erase_pkg::TPTR_WIDTH-1:flash_erase_pkg::ROW_LSB];
   wire row_invalid = (row_sel >= ROW_LIMIT);
   wire row_protected = (row_sel < prot_reg);

   // go written while keyed
   wire go_write = wr_ctrl & wdata[flash_erase_pkg::CTRL_GO_BIT];
   wire keyed = (state_reg == flash_erase_pkg::ST_KEYED);
   wire launch_try = go_write & keyed & setup_ok & ~go_bit;
   wire go_fault = launch_try & (row_invalid | row_protected);
   wire launch = launch_try & ~row_invalid & ~row_protected;
   wire abort_evt = abort_sync_reg[1] & (state_reg == flash_erase_pkg::ST_ERASE);
   wire timer_done = (state_reg == flash_erase_pkg::ST_ERASE) &
      (count_reg == CW'(ERASE_COUNT - 1));
   wire done_evt = timer_done & ~abort_evt;

   // sequence state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         flash_erase_pkg::ST_IDLE: begin
            if (wr_unlock && wdata == flash_erase_pkg::UNLOCK_KEY_A) begin
               state_next = flash_erase_pkg::ST_KEYED;
            end
         end
         flash_erase_pkg::ST_KEYED: begin
            if (launch) begin
               state_next = flash_erase_pkg::ST_ERASE;
            end else if (wr_unlock && wdata == flash_erase_pkg::UNLOCK_KEY_B) begin
               state_next = flash_erase_pkg::ST_KEYED;
            end else if (bus_wr) begin
               state_next = flash_erase_pkg::ST_IDLE;
            end
         end
         flash_erase_pkg::ST_ERASE: begin
            if (abort_evt || timer_done) begin
               state_next = flash_erase_pkg::ST_IDLE;
            end
         end
         default: state_next = flash_erase_pkg::ST_IDLE;
      endcase
   end

   // control register: go is hardware set and cleared, err is hardware set and software cleared, other bits software owned
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl && state_reg != flash_erase_pkg::ST_ERASE) begin
         ctrl_next = wdata;
         ctrl_next[flash_erase_pkg::CTRL_GO_BIT] = go_bit;
         ctrl_next[flash_erase_pkg::CTRL_ERR_BIT] = ctrl_reg[flash_erase_pkg::CTRL_ERR_BIT] &
            wdata[flash_erase_pkg::CTRL_ERR_BIT];
      end
      if (launch) begin
         ctrl_next[flash_erase_pkg::CTRL_GO_BIT] = 1'b1;
      end
      if (go_fault) begin
         ctrl_next[flash_erase_pkg::CTRL_GO_BIT] = 1'b0;
      end
      if (abort_evt || done_evt) begin
         ctrl_next[flash_erase_pkg::CTRL_GO_BIT] = 1'b0;
      end
      if (go_fault || abort_evt) begin
         ctrl_next[flash_erase_pkg::CTRL_ERR_BIT] = 1'b1;
      end
   end

   // sticky status, write one to clear, set wins
   always_comb begin
      status_next = status_reg;
      if (wr_status) begin
         status_next = status_reg & ~wdata[1:0];
      end
      if (done_evt) begin
         status_next[flash_erase_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      if (go_fault || abort_evt) begin
         status_next[flash_erase_pkg::IRQ_ERR_BIT] = 1'b1;
      end
   end

   // read mux
   logic [31:0] rdata_next;
   always_comb begin
      rdata_next = flash_erase_pkg::ZERO_WORD;
      unique case (wb_adr_i)
         flash_erase_pkg::CTRL_OFFSET: rdata_next[7:0] = ctrl_reg;
         flash_erase_pkg::UNLOCK_OFFSET: rdata_next[1:0] = state_reg;
         flash_erase_pkg::TPTR_OFFSET: rdata_next[flash_erase_pkg::TPTR_WIDTH-1:0] = tptr_reg;
         flash_erase_pkg::STATUS_OFFSET: rdata_next[1:0] = status_reg;
         flash_erase_pkg::MASK_OFFSET: rdata_next[1:0] = mask_reg;
         flash_erase_pkg::PROT_OFFSET: rdata_next[15:0] = prot_reg;
         default: rdata_next = flash_erase_pkg::ZERO_WORD;
      endcase
   end

   // table pointer write uses byte lanes, locked during erase
   logic [flash_erase_pkg::TPTR_WIDTH-1:0] tptr_next;
   always_comb begin
      tptr_next = tptr_reg;
      if (wr_tptr && state_reg != flash_erase_pkg::ST_ERASE) begin
         tptr_next[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) begin
            tptr_next[15:8] = wb_dat_i[15:8];
         end
         if (wb_sel_i[2]) begin
            tptr_next[21:16] = wb_dat_i[21:16];
         end
      end
   end

   // two flops tame the asynchronous abort pin; only the second one is read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         abort_sync_reg <= SYNC_RESET;
      end else if (clk_en) begin
         abort_sync_reg <= {abort_sync_reg[0], abort_pin};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= flash_erase_pkg::ST_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (clk_en) begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_reg <= FLAG_RESET;
      end else if (clk_en) begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tptr_reg <= '0;
      end else if (clk_en) begin
         tptr_reg <= tptr_next;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mask_reg <= FLAG_RESET;
      end else if (clk_en) begin
         if (wr_mask) begin
            mask_reg <= wdata[1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prot_reg <= PROT_RESET;
      end else if (clk_en) begin
         if (wr_prot && wb_sel_i[1]) begin
            prot_reg <= wb_dat_i[15:0];
         end
      end
   end

   // erase timer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_reg <= '0;
      end else if (clk_en) begin
         if (state_reg == flash_erase_pkg::ST_ERASE) begin
            count_reg <= count_reg + CW'(1);
         end else begin
            count_reg <= '0;
         end
      end
   end

   // bus reply: ack pulse and read data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         rdata_reg <= flash_erase_pkg::ZERO_WORD;
      end else if (clk_en) begin
         ack_reg <= bus_req;
         rdata_reg <= rdata_next;
      end
   end

   // cpu held while the erase runs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_stall <= 1'b0;
      end else if (clk_en) begin
         cpu_stall <= (state_next == flash_erase_pkg::ST_ERASE);
      end
   end

   // erase strobe at timer end, row index captured at launch
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         row_erase_strobe <= 1'b0;
         row_erase_index <= INDEX_RESET;
      end else if (clk_en) begin
         row_erase_strobe <= done_evt;
         if (launch) begin
            row_erase_index <= row_sel;
         end
      end
   end

   // level interrupt from status and mask
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(status_next & mask_reg);
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;
endmodule : program_flash_row_erase
`default_nettype wire

// >>> dv/program_flash_row_erase_asserts.sv
// checker: port-level properties of the row erase sequencer
`timescale 1ns/10ps
`default_nettype none
module program_flash_row_erase_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic cpu_stall,
   input wire logic row_erase_strobe,
   input wire logic [15:0] row_erase_index
);
   localparam int LIM = 1000;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence erase_start;
      $rose(cpu_stall);
   endsequence
   sequence erase_end;
      ##[1:LIM] (row_erase_strobe || !cpu_stall);
   endsequence
   ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   strobe_pulse_a: assert property (row_erase_strobe |=> !row_erase_strobe)
      else $error("erase strobe longer than one cycle");
   erase_bound_a: assert property (erase_start |-> erase_end)
      else $error("erase never ended");
   strobe_in_erase_a: assert property (row_erase_strobe |-> $past(cpu_stall))
      else $error("strobe outside erase");
   stall_end_a: assert property (row_erase_strobe |-> ##[0:2] !cpu_stall)
      else $error("cpu not resumed after erase");
   index_hold_a: assert property (cpu_stall && $past(cpu_stall) |-> $stable(row_erase_index))
      else $error("row index moved during erase");
endmodule : program_flash_row_erase_asserts
`default_nettype wire

// >>> dv/program_flash_row_erase_tb.sv
// testbench: directed scenarios for the row erase sequencer
`timescale 1ns/10ps
`default_nettype none
module program_flash_row_erase_tb;
   localparam int EC = 20;
   localparam logic [7:0] A_CT = flash_erase_pkg::CTRL_OFFSET;
   localparam logic [7:0] A_UN = flash_erase_pkg::UNLOCK_OFFSET;
   localparam logic [7:0] A_TP = flash_erase_pkg::TPTR_OFFSET;
   localparam logic [7:0] A_ST = flash_erase_pkg::STATUS_OFFSET;
   localparam logic [7:0] A_MK = flash_erase_pkg::MASK_OFFSET;
   localparam logic [7:0] A_PR = flash_erase_pkg::PROT_OFFSET;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic abort_pin = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic cpu_stall;
   logic row_erase_strobe;
   logic irq;
   logic [15:0] row_erase_index;
   logic [31:0] rd;
   int errors = 0;
   int total_checks = 0;
   always #2.5 clk = ~clk;
   program_flash_row_erase #(.ERASE_COUNT(EC)) DUT (
      .clk(clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i),
      .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .abort_pin(abort_pin),
      .cpu_stall(cpu_stall),
      .row_erase_strobe(row_erase_strobe),
      .row_erase_index(row_erase_index),
      .irq(irq)
   );
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task automatic launch(input logic [31:0] tp);
      xfer(A_TP, tp, 1'b1);
      xfer(A_CT, 32'h0000_009C, 1'b1);
      xfer(A_UN, {24'h00_0000, flash_erase_pkg::UNLOCK_KEY_A}, 1'b1);
      xfer(A_UN, {24'h00_0000, flash_erase_pkg::UNLOCK_KEY_B}, 1'b1);
      xfer(A_CT, 32'h0000_009E, 1'b1);
   endtask : launch
   task automatic t_good;
      int n;
      logic st;
      st = 1'b0;
      xfer(A_MK, 32'h0000_0003, 1'b1);
      launch(32'h0000_017F);
      for (n = 0; n < 60 && row_erase_strobe !== 1'b1; n++) begin
         @(posedge clk);
         st |= cpu_stall;
      end
      check(st, 1'b1);
      check(n < 60, 1'b1);
      check(row_erase_index, 16'h0005);
      repeat (2) @(posedge clk);
      check(cpu_stall, 1'b0);
      xfer(A_CT, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_0094);
      xfer(A_ST, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_0001);
      check(irq, 1'b1);
      xfer(A_MK, 32'h0000_0000, 1'b1);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      xfer(A_ST, 32'h0000_0001, 1'b1);
      $display("test good erase done");
   endtask : t_good
   task automatic t_refused(input logic [31:0] prot, input logic [31:0] tp);
      xfer(A_PR, prot, 1'b1);
      launch(tp);
      repeat (2) @(posedge clk);
      check(cpu_stall, 1'b0);
      xfer(A_CT, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_009C);
      xfer(A_ST, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_0002);
      xfer(A_PR, 32'h0000_0000, 1'b1);
      launch(32'h0000_0800);
      repeat (EC + 4) @(posedge clk);
      xfer(A_CT, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_009C);
      xfer(A_CT, 32'h0000_0094, 1'b1);
      xfer(A_ST, 32'h0000_0003, 1'b1);
      $display("test refused erase done");
   endtask : t_refused
   task automatic t_abort;
      logic seen;
      seen = 1'b0;
      launch(32'h0000_01C0);
      repeat (2) @(posedge clk);
      abort_pin <= 1'b1;
      repeat (4) @(posedge clk);
      abort_pin <= 1'b0;
      repeat (EC + 4) begin
         @(posedge clk);
         seen |= row_erase_strobe;
      end
      check(seen, 1'b0);
      check(cpu_stall, 1'b0);
      xfer(A_CT, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_009C);
      $display("test abort done");
   endtask : t_abort
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      check(irq, 1'b0);
      xfer(A_CT, 32'h0000_0000, 1'b0);
      check(rd, 32'h0000_0000);
      t_good;
      t_refused(32'h0000_0010, 32'h0000_0140);
      t_refused(32'h0000_0000, 32'h0001_0000);
      t_abort;
      close_out;
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      close_out;
   end
endmodule : program_flash_row_erase_tb
bind program_flash_row_erase program_flash_row_erase_asserts chk (
   .clk(clk),
   .rstn(rstn),
   .clk_en(clk_en),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .cpu_stall(cpu_stall),
   .row_erase_strobe(row_erase_strobe),
   .row_erase_index(row_erase_index)
);
`default_nettype wire
